// ==== sacc_pkg.sv ====
// Purpose: shared constants for the converter conversion control block
// Assumes: 8-bit special function register bus, one system clock
// Notes: offsets are the register addresses of the core's bus
package sacc_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_ADDR = 8'hbc;
    localparam logic [7:0] CTRL_ADDR = 8'he8;
    localparam logic [7:0] RES_HI_ADDR = 8'hbe;
    localparam logic [7:0] RES_LO_ADDR = 8'hbd;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int DIV_MSB = 7;
    localparam int DIV_LSB = 3;
    localparam int LJST_BIT = 2;
    localparam int EN_BIT = 7;
    localparam int TM_BIT = 6;
    localparam int DONE_BIT = 5;
    localparam int BUSY_BIT = 4;
    localparam int WINT_BIT = 3;
    localparam int SRC_MSB = 2;
    localparam logic [7:0] CFG_RESET = 8'hf8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // ------------------------------------------------------------
    // start sources and timing counts
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_SW = 3'h0;
    localparam logic [2:0] SRC_TMR0 = 3'h1;
    localparam logic [2:0] SRC_TMR2 = 3'h2;
    localparam logic [2:0] SRC_TMR1 = 3'h3;
    localparam logic [2:0] SRC_PIN = 3'h4;
    localparam logic [2:0] SRC_TMR3 = 3'h5;
    localparam logic [2:0] SRC_TMR4 = 3'h6;
    localparam logic [2:0] SRC_TMR5 = 3'h7;
    localparam logic [3:0] TRACK_SAR_CLKS = 4'h3;
    localparam logic [3:0] CONV_SAR_CLKS = 4'hb;
endpackage

// ==== sacc_clkdiv.sv ====
// Purpose: sar conversion clock tick generator
// Assumes: divider value sampled every cycle
// Notes: one tick every div+1 system clocks, free while enabled
`timescale 1ns/10ps
module sacc_clkdiv #(
    parameter int DIV_W = 5
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic run_i,
    input wire logic [DIV_W-1:0] div_i,
    output logic tick_o
);
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;

    // counter compare is not served beyond 8 bits
    if (DIV_W < 1 || DIV_W > 8) begin : g_bad_width
        $error("sacc_clkdiv: DIV_W out of range");
    end

    always_comb begin
        next_cnt = cnt;
        if (!run_i || cnt >= div_i) begin
            next_cnt = '0;
        end else begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign tick_o = run_i && (cnt >= div_i);
endmodule

// ==== sacc_top.sv ====
// Purpose: conversion control for a 10-bit sar converter
// Assumes: core register port with byte writes and reads, same clock
// Notes: analog core driven through track/convert strobes
`timescale 1ns/10ps
module sacc_top (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [5:0] tmr_lo_ovf_i,
    input wire logic [5:0] tmr_hi_ovf_i,
    input wire logic [5:0] tmr_16bit_i,
    input wire logic external_start_pin_i,
    input wire logic standby_i,
    input wire logic eight_bit_result_enable_i,
    input wire logic irq_enable_i,
    input wire logic [9:0] sar_code_i,
    output logic converter_enable_o,
    output logic track_o,
    output logic convert_o,
    output logic irq_o
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TRACK = 2'b01,
        ST_CONV = 2'b10
    } sacc_state_e;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] converter_config_reg;
    logic [7:0] converter_control_reg;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic [7:0] next_cfg;
    logic [7:0] next_ctrl;
    logic [7:0] next_hi;
    logic [7:0] next_lo;
    sacc_state_e state;
    sacc_state_e next_state;
    logic [3:0] sar_cnt;
    logic [3:0] next_sar_cnt;
    logic pin_s1;
    logic pin_s2;
    logic pin_d;
    logic busy_d;
    logic sar_tick;
    logic start_evt;
    logic pin_rise;
    logic [2:0] src;
    logic low_power;
    logic busy_fall;
    logic [15:0] justified;

    assign src = converter_control_reg[sacc_pkg::SRC_MSB:0];
    assign converter_enable_o = converter_control_reg[sacc_pkg::EN_BIT];
    assign low_power = converter_control_reg[sacc_pkg::TM_BIT];

    // ------------------------------------------------------------
    // sar clock
    // ------------------------------------------------------------
    // sar tick divider
    sacc_clkdiv #(
        .DIV_W(5)
    ) u_div (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(converter_enable_o),
        .div_i(converter_config_reg[sacc_pkg::DIV_MSB:sacc_pkg::DIV_LSB]),
        .tick_o(sar_tick)
    );

    // ------------------------------------------------------------
    // start source selection
    // ------------------------------------------------------------
    // pin passes two flops; only the second feeds the edge detector
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_d <= 1'b0;
            busy_d <= 1'b0;
        end else begin
            pin_s1 <= external_start_pin_i;
            pin_s2 <= pin_s1;
            pin_d <= pin_s2;
            busy_d <= converter_control_reg[sacc_pkg::BUSY_BIT];
        end
    end

    assign pin_rise = pin_s2 && !pin_d;

    function automatic logic tmr_ovf(input int idx, input logic byte_mode);
        tmr_ovf = (tmr_16bit_i[idx] ? tmr_hi_ovf_i[idx] : tmr_lo_ovf_i[idx]);
        if (byte_mode) begin
            tmr_ovf = tmr_hi_ovf_i[idx];
        end
    endfunction

    always_comb begin
        case (src)
            sacc_pkg::SRC_SW: start_evt = reg_wr_i
                && reg_addr_i == sacc_pkg::CTRL_ADDR
                && reg_wdata_i[sacc_pkg::BUSY_BIT];
            sacc_pkg::SRC_TMR0: start_evt = tmr_ovf(0, 1'b1);
            sacc_pkg::SRC_TMR2: start_evt = tmr_ovf(2, 1'b0);
            sacc_pkg::SRC_TMR1: start_evt = tmr_ovf(1, 1'b1);
            sacc_pkg::SRC_PIN: start_evt = pin_rise;
            sacc_pkg::SRC_TMR3: start_evt = tmr_ovf(3, 1'b0);
            sacc_pkg::SRC_TMR4: start_evt = tmr_ovf(4, 1'b0);
            sacc_pkg::SRC_TMR5: start_evt = tmr_ovf(5, 1'b0);
            default: start_evt = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // track and convert sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_sar_cnt = sar_cnt;
        case (state)
            ST_IDLE: begin
                if (converter_enable_o && start_evt) begin
                    next_sar_cnt = 4'h0;
                    if (low_power && src != sacc_pkg::SRC_PIN) begin
                        next_state = ST_TRACK;
                    end else begin
                        next_state = ST_CONV;
                    end
                end
            end
            ST_TRACK: begin
                if (sar_tick) begin
                    if (sar_cnt == sacc_pkg::TRACK_SAR_CLKS - 4'h1) begin
                        next_state = ST_CONV;
                        next_sar_cnt = 4'h0;
                    end else begin
                        next_sar_cnt = sar_cnt + 4'h1;
                    end
                end
            end
            ST_CONV: begin
                if (sar_tick) begin
                    if (sar_cnt == sacc_pkg::CONV_SAR_CLKS - 4'h1) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_sar_cnt = sar_cnt + 4'h1;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (!converter_enable_o) begin
            next_state = ST_IDLE;
            next_sar_cnt = 4'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
            sar_cnt <= 4'h0;
        end else begin
            state <= next_state;
            sar_cnt <= next_sar_cnt;
        end
    end

    always_comb begin
        track_o = 1'b0;
        if (converter_enable_o && !standby_i) begin
            if (state == ST_TRACK) begin
                track_o = 1'b1;
            end else if (state == ST_IDLE) begin
                track_o = !(low_power && src == sacc_pkg::SRC_PIN) || !pin_s2;
            end
        end
    end
    assign convert_o = (state == ST_CONV);

    // ------------------------------------------------------------
    // result formatting and register file
    // ------------------------------------------------------------
    // justification only in 10-bit mode
    always_comb begin
        if (eight_bit_result_enable_i) begin
            justified = {8'h00, sar_code_i[9:2]};
        end else if (converter_config_reg[sacc_pkg::LJST_BIT]) begin
            justified = {sar_code_i, 6'h00};
        end else begin
            justified = {6'h00, sar_code_i};
        end
    end

    // busy follows the conversion, not the write
    assign busy_fall = busy_d && !converter_control_reg[sacc_pkg::BUSY_BIT];

    always_comb begin
        next_cfg = converter_config_reg;
        next_ctrl = converter_control_reg;
        next_hi = result_high_byte;
        next_lo = result_low_byte;
        if (reg_wr_i && reg_addr_i == sacc_pkg::CFG_ADDR) begin
            next_cfg = {reg_wdata_i[7:2], 2'b00};
        end
        if (reg_wr_i && reg_addr_i == sacc_pkg::CTRL_ADDR) begin
            next_ctrl[7:5] = reg_wdata_i[7:5];
            next_ctrl[3:0] = reg_wdata_i[3:0];
        end
        if (reg_wr_i && reg_addr_i == sacc_pkg::RES_HI_ADDR) begin
            next_hi = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == sacc_pkg::RES_LO_ADDR) begin
            next_lo = reg_wdata_i;
        end
        next_ctrl[sacc_pkg::BUSY_BIT] = (next_state != ST_IDLE);
        // results land with busy falling, one cycle before the done flag
        if (state == ST_CONV && next_state == ST_IDLE && converter_enable_o) begin
            next_hi = justified[15:8];
            next_lo = justified[7:0];
        end
        // set wins over a software clear
        if (busy_fall) begin
            next_ctrl[sacc_pkg::DONE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            converter_config_reg <= sacc_pkg::CFG_RESET;
            converter_control_reg <= sacc_pkg::CTRL_RESET;
            result_high_byte <= 8'h00;
            result_low_byte <= 8'h00;
        end else begin
            converter_config_reg <= next_cfg;
            converter_control_reg <= next_ctrl;
            result_high_byte <= next_hi;
            result_low_byte <= next_lo;
        end
    end

    assign irq_o = converter_control_reg[sacc_pkg::DONE_BIT] && irq_enable_i;

    always_comb begin
        case (reg_addr_i)
            sacc_pkg::CFG_ADDR: reg_rdata_o = converter_config_reg;
            sacc_pkg::CTRL_ADDR: reg_rdata_o = converter_control_reg;
            sacc_pkg::RES_HI_ADDR: reg_rdata_o = result_high_byte;
            sacc_pkg::RES_LO_ADDR: reg_rdata_o = result_low_byte;
            default: reg_rdata_o = 8'h00;
        endcase
        if (!reg_rd_i) begin
            reg_rdata_o = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_busy_tracks_fsm: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        $rose(converter_control_reg[sacc_pkg::BUSY_BIT])
        |-> $past(start_evt) && $past(converter_enable_o))
        else $error("busy bit rose without a start");
    chk_done_on_fall: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        $fell(converter_control_reg[sacc_pkg::BUSY_BIT])
        |=> converter_control_reg[sacc_pkg::DONE_BIT])
        else $error("done flag not set after busy fell");
    chk_off_idle: assert property (@(posedge clk_i)
        disable iff (sys_rst_i) !converter_enable_o |=> state == ST_IDLE)
        else $error("sequencer active while disabled");
    chk_pin_no_delay: assert property (@(posedge clk_i)
        disable iff (sys_rst_i) src == sacc_pkg::SRC_PIN && state == ST_IDLE
        |=> state != ST_TRACK) else $error("track delay on pin start");
    chk_lp_track: assert property (@(posedge clk_i)
        disable iff (sys_rst_i) state == ST_IDLE && converter_enable_o
        && start_evt && low_power && src != sacc_pkg::SRC_PIN
        |=> state == ST_TRACK) else $error("no tracking delay");
    chk_normal_direct: assert property (@(posedge clk_i)
        disable iff (sys_rst_i) state == ST_IDLE && !low_power
        |=> state != ST_TRACK) else $error("track delay in normal mode");
    chk_sw_start: assert property (@(posedge clk_i)
        disable iff (sys_rst_i) state == ST_IDLE && converter_enable_o
        && start_evt && src == sacc_pkg::SRC_SW |=> state != ST_IDLE)
        else $error("software start ignored");
    chk_irq_gate: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        $fell(converter_control_reg[sacc_pkg::BUSY_BIT])
        |=> irq_o == irq_enable_i)
        else $error("interrupt request not raised");
    chk_standby_track: assert property (@(posedge clk_i)
        disable iff (sys_rst_i) standby_i |-> !track_o)
        else $error("tracking during standby");
    cov_lp_conv: cover property (@(posedge clk_i)
        state == ST_TRACK ##1 state == ST_CONV);
    cov_done: cover property (@(posedge clk_i)
        $rose(converter_control_reg[sacc_pkg::DONE_BIT]));
    cov_pin: cover property (@(posedge clk_i) pin_rise && state == ST_IDLE);
endmodule

// ==== sacc_far_end.sv ====
// Purpose: far side of the conversion control: timers, pin, analog core
// Assumes: bench commands every timer strobe and the pin level
// Notes: code lines show the inverse of the code outside conversions
`timescale 1ns/10ps
module sacc_far_end #(
    parameter logic [9:0] CODE = 10'h2b7
) (
    input wire logic [5:0] fire_lo_i,
    input wire logic [5:0] fire_hi_i,
    input wire logic [5:0] mode16_i,
    input wire logic pin_level_i,
    input wire logic converting_i,
    output logic [5:0] tmr_lo_ovf_o,
    output logic [5:0] tmr_hi_ovf_o,
    output logic [5:0] tmr_16bit_o,
    output logic external_start_pin_o,
    output logic [9:0] sar_code_o
);
    // ------------------------------------------------------------
    // timers and start pin
    // ------------------------------------------------------------
    // strobes last exactly as long as the bench holds them
    assign tmr_lo_ovf_o = fire_lo_i;
    assign tmr_hi_ovf_o = fire_hi_i;
    assign tmr_16bit_o = mode16_i;
    assign external_start_pin_o = pin_level_i;
    // ------------------------------------------------------------
    // analog core
    // ------------------------------------------------------------
    // inverse outside conversions so a stale sample cannot match
    assign sar_code_o = converting_i ? CODE : ~CODE;
endmodule

// ==== sacc_top_test.sv ====
// Purpose: self-checking bench for the conversion control block
// Assumes: register port as in the hand-over, one 100 MHz clock
// Notes: conversion lengths checked in windows, tick phase is free
`timescale 1ns/10ps
module sacc_top_test;
    localparam logic [9:0] CODE = 10'h2b7;
    localparam logic [7:0] CTRL = sacc_pkg::CTRL_ADDR;
    localparam logic [7:0] CFG = sacc_pkg::CFG_ADDR;
    // divider nonzero, rate under 500 ksps
    localparam logic [7:0] CFG_FAST = 8'h98;
    localparam int TIDX [8] = '{0, 0, 2, 1, 4, 3, 4, 5};
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [5:0] fire_lo = 6'h00;
    logic [5:0] fire_hi = 6'h00;
    logic [5:0] mode16 = 6'h00;
    logic pin_level = 1'b0;
    logic standby_i = 1'b0;
    logic eight_bit = 1'b0;
    logic irq_en = 1'b1;
    logic [5:0] lo_ovf, hi_ovf, m16;
    logic pin, en_o, track, conv, irq;
    logic [9:0] code;
    int fail_count = 0;
    int checks_done = 0;

    always #5 clk_i = ~clk_i;

    sacc_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .tmr_lo_ovf_i(lo_ovf), .tmr_hi_ovf_i(hi_ovf), .tmr_16bit_i(m16),
        .external_start_pin_i(pin), .standby_i(standby_i),
        .eight_bit_result_enable_i(eight_bit), .irq_enable_i(irq_en),
        .sar_code_i(code), .converter_enable_o(en_o), .track_o(track),
        .convert_o(conv), .irq_o(irq));
    sacc_far_end #(.CODE(CODE)) i_far (.fire_lo_i(fire_lo),
        .fire_hi_i(fire_hi), .mode16_i(mode16), .pin_level_i(pin_level),
        .converting_i(conv), .tmr_lo_ovf_o(lo_ovf), .tmr_hi_ovf_o(hi_ovf),
        .tmr_16bit_o(m16), .external_start_pin_o(pin), .sar_code_o(code));

    // ------------------------------------------------------------
    // bus and measuring tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(negedge clk_i);
        v = reg_rdata_o;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask
    task automatic wait_rise(output int n);
        n = 0;
        @(negedge clk_i);
        while (conv !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    // bounded so a stuck convert strobe cannot hang the run
    task automatic conv_len(output int n);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (conv === 1'b1 && n < 400);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] v;
        rd(CFG, v);
        check(v, 8'hf8);
        rd(CTRL, v);
        check(v, 8'h00);
        rd(sacc_pkg::RES_LO_ADDR, v);
        check(v, 8'h00);
        check(en_o, 1'b0);
        wr(CFG, 8'hff);
        rd(CFG, v);
        check(v, 8'hfc);
    endtask
    task automatic t_sw(input logic [7:0] cfg, input int lo, input int hi,
                        input logic [7:0] ehi, input logic [7:0] elo);
        logic [7:0] v;
        int n;
        wr(CFG, cfg);
        wr(CTRL, 8'h80);
        @(negedge clk_i);
        check(track, 1'b1);
        check(en_o, 1'b1);
        wr(CTRL, 8'h90);
        wait_rise(n);
        check(16'(n), 16'h0000);
        check(track, 1'b0);
        rd(CTRL, v);
        check(v, 8'h90);
        conv_len(n);
        check(n + 2 >= lo && n + 2 <= hi, 1'b1);
        rd(CTRL, v);
        check(v, 8'ha0);
        check(irq, irq_en);
        rd(sacc_pkg::RES_HI_ADDR, v);
        check(v, ehi);
        rd(sacc_pkg::RES_LO_ADDR, v);
        check(v, elo);
        wr(CTRL, 8'h80);
        @(negedge clk_i);
        check(irq, 1'b0);
        @(posedge clk_i);
    endtask
    task automatic t_src();
        int t, n;
        logic usehi;
        logic [5:0] right;
        for (int s = 1; s < 8; s++) begin
            t = TIDX[s];
            right = 6'h01 << t;
            usehi = (t < 2) || s[0];
            wr(CTRL, 8'h80 | 8'(s));
            @(posedge clk_i);
            mode16 <= s[0] ? right : 6'h00;
            fire_hi <= (s == 4 || !usehi) ? 6'h3f : ~right;
            fire_lo <= (s == 4 || usehi) ? 6'h3f : ~right;
            @(posedge clk_i);
            fire_hi <= 6'h00;
            fire_lo <= 6'h00;
            repeat (6) @(negedge clk_i);
            check(conv, 1'b0);
            @(posedge clk_i);
            if (s == 4) pin_level <= 1'b1;
            else if (usehi) fire_hi <= right;
            else fire_lo <= right;
            @(posedge clk_i);
            fire_hi <= 6'h00;
            fire_lo <= 6'h00;
            wait_rise(n);
            check(n <= 5, 1'b1);
            conv_len(n);
            check(n >= 200 && n <= 222, 1'b1);
            wr(CTRL, 8'h80);
            pin_level <= 1'b0;
        end
    endtask
    task automatic t_lp();
        logic [7:0] v;
        int n;
        // mode first: the starting write still sees the old mode
        wr(CTRL, 8'hc0);
        wr(CTRL, 8'hd0);
        @(negedge clk_i);
        check(track, 1'b1);
        wait_rise(n);
        check(n >= 40 && n <= 59, 1'b1);
        conv_len(n);
        check(n >= 200 && n <= 222, 1'b1);
        wr(CTRL, 8'hc4);
        repeat (4) @(negedge clk_i);
        check(track, 1'b1);
        @(posedge clk_i);
        pin_level <= 1'b1;
        wait_rise(n);
        check(n <= 5, 1'b1);
        conv_len(n);
        check(track, 1'b0);
        wr(CTRL, 8'h80);
        standby_i <= 1'b1;
        pin_level <= 1'b0;
        @(negedge clk_i);
        check(track, 1'b0);
        @(posedge clk_i);
        standby_i <= 1'b0;
        // disable first, then try a start while off
        wr(CTRL, 8'h00);
        wr(CTRL, 8'h10);
        repeat (30) @(negedge clk_i);
        check(conv, 1'b0);
        rd(CTRL, v);
        check(v, 8'h00);
    endtask

    task automatic results();
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_sw(8'hf8, 320, 356, {6'h00, CODE[9:8]}, CODE[7:0]);
        t_sw(CFG_FAST, 200, 224, {6'h00, CODE[9:8]}, CODE[7:0]);
        irq_en <= 1'b0;
        t_sw(CFG_FAST | 8'h04, 200, 224, CODE[9:2], {CODE[1:0], 6'h00});
        eight_bit <= 1'b1;
        t_sw(CFG_FAST | 8'h04, 200, 224, 8'h00, CODE[9:2]);
        eight_bit <= 1'b0;
        irq_en <= 1'b1;
        t_src();
        t_lp();
        results();
    end

    // whole run is a few thousand cycles
    initial begin
        repeat (30000) @(posedge clk_i);
        fail_count++;
        results();
    end
endmodule
